// ### hw/clk_switch.sv
// system clock source switch: control registers and switch sequencing
`timescale 1ns/1ps
`default_nettype none
module clk_switch
   import clk_switch_pkg::*;
(
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic wr_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic unlock_i,
   output logic [7:0] rdata_o,
   input wire logic fast_osc_ready_i,
   input wire logic slow_osc_ready_i,
   input wire logic ext_clock_ready_i,
   input wire logic self_program_enable_i,
   input wire logic [2:0] osc_i,
   output logic fast_osc_on_o,
   output logic ext_clock_pin_on_o,
   output logic [1:0] active_src_o,
   output logic sys_clk_o
);
   logic [1:0] sel_q;
   logic [1:0] ext_en_q;
   logic fast_en_q;
   logic fault_q;
   logic [1:0] act_q;
   logic [7:0] rdata_q;
   logic fast_on_q;
   logic ext_on_q;
   logic [1:0] act_o_q;
   logic [2:0] gate;
   logic mux_clk;

   function automatic logic src_ok(input logic [1:0] s, input logic fe,
      input logic fr, input logic sr, input logic ee, input logic er);
      src_ok = (s == src_fast) ? (fe & fr) :
               (s == src_slow) ? sr :
               (s == src_ext) ? (ee & er) : 1'b0;
   endfunction : src_ok

   function automatic logic src_en(input logic [1:0] s, input logic fe,
      input logic ee);
      src_en = (s == src_fast) ? fe :
               (s == src_slow) ? 1'b1 :
               (s == src_ext) ? ee : 1'b0;
   endfunction : src_en

   wire wr_sw = wr_i && unlock_i && (addr_i == switch_addr);
   wire wr_en = wr_i && unlock_i && (addr_i == enable_addr);
   wire [1:0] new_sel = wdata_i[sel_lo_bit +: 2];
   wire [1:0] new_ext = wdata_i[ext_en_lo_bit +: 2];
   wire new_fast = wdata_i[fast_en_bit];
   wire fast_eff = fast_en_q | self_program_enable_i;
   wire ext_eff = (ext_en_q == ext_on_code);
   wire fast_st = fast_eff & fast_osc_ready_i;
   wire ext_st = ext_eff & ext_clock_ready_i;
   wire new_ok = src_ok(new_sel, fast_eff, fast_osc_ready_i,
      slow_osc_ready_i, ext_eff, ext_clock_ready_i);
   // discard if the active source would lose its enable
   // the forced enable is ignored here: it lapses when programming ends
   wire kills_active = (act_q == src_fast && !new_fast) ||
      (act_q == src_ext && new_ext != ext_on_code);
   wire sel_ok = src_ok(sel_q, fast_eff, fast_osc_ready_i,
      slow_osc_ready_i, ext_eff, ext_clock_ready_i);
   wire pend = (sel_q != act_q);
   wire [1:0] hw_fields_sw = {fast_st, slow_osc_ready_i};
   wire [7:0] sw_view = {2'h0, hw_fields_sw, ext_st, sel_q, 1'b0};
   // spare bit 4 reads as one so the reset image is 0011 0000
   wire [7:0] en_view = {ext_en_q, fast_eff, 1'b1, 3'h0, fault_q};
   wire [7:0] rd_next = (addr_i == switch_addr) ? sw_view :
                        (addr_i == enable_addr) ? en_view : 8'h00;

   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         sel_q <= src_fast;
         ext_en_q <= 2'h0;
         fast_en_q <= 1'b1;
      end
      else
      begin
         if (wr_sw)
            sel_q <= new_sel;
         if (wr_en && !kills_active)
         begin
            ext_en_q <= new_ext;
            fast_en_q <= new_fast;
         end
      end
   end

   // active source moves only to an enabled and stable target
   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         act_q <= src_fast;
         fault_q <= 1'b0;
      end
      else if (wr_sw && new_sel != act_q)
      begin
         // flag now; the switch itself is deferred one cycle minimum
         fault_q <= !src_ok(new_sel, fast_eff, fast_osc_ready_i,
            slow_osc_ready_i, ext_eff, ext_clock_ready_i);
      end
      else if (wr_sw)
         fault_q <= 1'b0;
      else if (pend && sel_ok && src_en(sel_q, fast_eff, ext_eff))
      begin
         act_q <= sel_q;
         fault_q <= 1'b0;
      end
   end

   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         rdata_q <= 8'h00;
         fast_on_q <= 1'b1;
         ext_on_q <= 1'b0;
         act_o_q <= src_fast;
      end
      else
      begin
         rdata_q <= rd_next;
         fast_on_q <= fast_eff;
         ext_on_q <= ext_eff;
         act_o_q <= act_q;
      end
   end

   src_mux u_mux (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .target_i(act_q),
      .osc_i(osc_i),
      .gate_o(gate),
      .clk_o(mux_clk)
   );

   // the gated clock is combinational by nature; registering it would halve it
   assign sys_clk_o = mux_clk;
   assign rdata_o = rdata_q;
   assign fast_osc_on_o = fast_on_q;
   assign ext_clock_pin_on_o = ext_on_q;
   assign active_src_o = act_o_q;

   // all checks share the one clock and are muted while reset is held
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (rst_i);

   sequence s_sw_write_bad;
      wr_sw && new_sel != act_q && !new_ok;
   endsequence

   sequence s_switch_taken;
      !wr_sw && pend && sel_ok;
   endsequence

   sequence s_legs_closed;
      gate == 3'h0;
   endsequence

   chk_locked_write_ignored: assert property (
      (wr_i && !unlock_i) |=> $stable(sel_q) && $stable(ext_en_q))
      else $error("unlocked write changed a register");

   chk_locked_fast_kept: assert property (
      (wr_i && !unlock_i) |=> $stable(fast_en_q))
      else $error("unlocked write changed fast enable");

   chk_locked_fault_kept: assert property (
      (wr_i && !unlock_i && !pend) |=> $stable(fault_q))
      else $error("unlocked write changed fault flag");

   chk_active_kept_on: assert property (
      (wr_en && kills_active) |=> $stable(ext_en_q) && $stable(fast_en_q))
      else $error("active source enable was changed");

   chk_active_src_kept: assert property (
      (wr_en && kills_active && !pend) |=> $stable(act_q))
      else $error("discarded write moved the active source");

   chk_bad_select_flag: assert property (
      s_sw_write_bad |=> fault_q && sel_q == $past(new_sel) && $stable(act_q))
      else $error("bad select did not flag");

   chk_deferred_switch: assert property (
      s_switch_taken |=> act_q == $past(sel_q))
      else $error("stable target not taken");

   chk_fault_holds: assert property (
      (fault_q && !wr_sw && !(pend && sel_ok)) |=> fault_q)
      else $error("fault dropped while target not ready");

   chk_no_early_switch: assert property (
      (!(pend && sel_ok) || wr_sw) |=> $stable(act_q))
      else $error("source moved before target was stable");

   chk_fault_clears: assert property (
      s_switch_taken |=> !fault_q)
      else $error("fault not cleared after switch");

   chk_fast_status: assert property (
      sw_view[fast_st_bit] == (fast_eff && fast_osc_ready_i))
      else $error("fast status wrong");

   chk_ext_status: assert property (
      sw_view[ext_st_bit] == (ext_en_q == 2'h3 && ext_clock_ready_i))
      else $error("external status wrong");

   chk_select_lands: assert property (
      wr_sw |=> sel_q == $past(new_sel))
      else $error("select write did not land");

   chk_rsvd_select_flag: assert property (
      (wr_sw && new_sel == src_rsvd) |=> fault_q)
      else $error("reserved select did not flag");

   chk_active_valid: assert property (
      act_q != src_rsvd)
      else $error("reserved source went active");

   chk_select_readback: assert property (
      sw_view[sel_lo_bit +: 2] == sel_q)
      else $error("select readback wrong");

   chk_sel_kept: assert property (
      !wr_sw |=> $stable(sel_q))
      else $error("select field changed without a write");

   chk_ext_write_lands: assert property (
      (wr_en && !kills_active) |=> ext_en_q == $past(new_ext))
      else $error("external enable write did not land");

   chk_ext_pin_out: assert property (
      1'b1 |=> ext_clock_pin_on_o == $past(ext_eff))
      else $error("external pin output wrong");

   chk_fast_write_lands: assert property (
      (wr_en && !kills_active) |=> fast_en_q == $past(new_fast))
      else $error("fast enable write did not land");

   chk_fast_en_view: assert property (
      en_view[fast_en_bit] == fast_eff)
      else $error("fast enable readback wrong");

   chk_fast_out: assert property (
      1'b1 |=> fast_osc_on_o == $past(fast_eff))
      else $error("fast oscillator output wrong");

   chk_iap_forces: assert property (
      self_program_enable_i |=> fast_osc_on_o)
      else $error("self programming did not force oscillator");

   chk_iap_status: assert property (
      (self_program_enable_i && fast_osc_ready_i) |-> sw_view[fast_st_bit])
      else $error("self programming did not set fast status");

   chk_good_select_clear: assert property (
      (wr_sw && new_ok) |=> !fault_q)
      else $error("good select left fault set");

   chk_same_select_clear: assert property (
      (wr_sw && new_sel == act_q) |=> !fault_q)
      else $error("select of running source left fault set");

   chk_fault_view: assert property (
      en_view[fault_bit] == fault_q)
      else $error("fault readback wrong");

   chk_slow_status: assert property (
      sw_view[slow_st_bit] == slow_osc_ready_i)
      else $error("slow status wrong");

   chk_switch_spare: assert property (
      sw_view[7:6] == 2'h0 && sw_view[0] == 1'b0)
      else $error("switch spare bits wrong");

   chk_read_data: assert property (
      1'b1 |=> rdata_o == $past(rd_next))
      else $error("read data wrong");

   chk_enable_spare: assert property (
      en_view[4:1] == 4'h8)
      else $error("enable spare bits wrong");

   chk_active_out: assert property (
      1'b1 |=> active_src_o == $past(act_q))
      else $error("active source output wrong");

   chk_one_gate: assert property (
      $onehot0(gate))
      else $error("two clock legs open together");

   // the old leg must shut before the new one may open
   chk_break_first: assert property (
      s_switch_taken |=> ##[1:3] s_legs_closed)
      else $error("old clock leg did not close");
endmodule : clk_switch
`default_nettype wire

// ### hw/clk_switch_pkg.sv
// package: register map, field layout and reset values of the clock switch
//
// Contract
// - control writes accepted only when access unlocked
// - write disabling active source is discarded whole
// - selecting disabled source: field updates, flag set
// - enabled unstable target: wait, switch later, flag
// - deferred switch done clears fault flag
// - bit 5 reads fast oscillator enabled and stable
// - bit 3 reads external clock enabled and stable
// - select field bits 2:1 chooses system source
// - select field readback not the running source
// - external enable field active only at 11
// - enable bit 5 switches fast oscillator
// - self programming forces fast oscillator on
// - fault flag bit 0 reports last switch
// - switch register resets to 0011 0000
// - enable register resets to 0011 0000
// - after reset fast oscillator runs selected
package clk_switch_pkg;
   localparam logic [7:0] switch_addr = 8'h96;
   localparam logic [7:0] enable_addr = 8'h97;
   localparam logic [7:0] switch_reset = 8'h30;
   localparam logic [7:0] enable_reset = 8'h30;
   localparam int fast_st_bit = 5;
   localparam int slow_st_bit = 4;
   localparam int ext_st_bit = 3;
   localparam int sel_lo_bit = 1;
   localparam int ext_en_lo_bit = 6;
   localparam int fast_en_bit = 5;
   localparam int fault_bit = 0;
   localparam logic [1:0] ext_on_code = 2'h3;
   // cycles each old/new clock must be quiet before handing over
   localparam logic [1:0] sync_stages = 2'h2;

   typedef enum logic [1:0]
   {
      src_fast = 2'b00,
      src_ext = 2'b01,
      src_slow = 2'b10,
      src_rsvd = 2'b11
   } src_e;
endpackage : clk_switch_pkg

// ### hw/clk_gate_sync.sv
// one gated source leg of the glitch-free clock mux
`timescale 1ns/1ps
`default_nettype none
module clk_gate_sync
   import clk_switch_pkg::*;
(
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic want_i,
   output logic on_o
);
   logic s1_q;
   logic s2_q;
   // two stages so the gate only changes well clear of the source edge
   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
      end
      else
      begin
         s1_q <= want_i;
         s2_q <= s1_q;
      end
   end
   assign on_o = s2_q;
endmodule : clk_gate_sync
`default_nettype wire

// ### hw/src_mux.sv
// break-before-make selection between the three sources
`timescale 1ns/1ps
`default_nettype none
module src_mux
   import clk_switch_pkg::*;
(
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic [1:0] target_i,
   input wire logic [2:0] osc_i,
   output logic [2:0] gate_o,
   output logic clk_o
);
   logic [2:0] want;
   logic [2:0] on;
   genvar g;
   generate
      for (g = 0; g < 3; g++)
      begin : leg
         // a leg may open only after every other leg has closed
         assign want[g] = (target_i == 2'(g)) && ((on & ~(3'h1 << g)) == 3'h0);
         clk_gate_sync u_sync (
            .mclk_i(mclk_i),
            .rst_i(rst_i),
            .want_i(want[g]),
            .on_o(on[g])
         );
      end
   endgenerate
   assign gate_o = on;
   assign clk_o = |(on & osc_i);
endmodule : src_mux
`default_nettype wire

// ### bench/tb.sv
// self-checking bench for the clock source switch
`timescale 1ns/1ps
`default_nettype none
module tb;
   import clk_switch_pkg::*;
   typedef struct packed
   {
      logic w;
      logic [7:0] a;
      logic [7:0] d;
      logic [2:0] r;
      logic [1:0] act;
      logic [7:0] sw;
      logic [7:0] en;
   } row_s;
   logic mclk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wr_i = 1'b0;
   logic [7:0] addr_i = 8'h00;
   logic [7:0] wdata_i = 8'h00;
   logic unlock_i = 1'b0;
   logic [2:0] rdy = 3'h6;
   logic prog = 1'b0;
   logic [3:0] cnt = 4'h0;
   wire logic [2:0] osc = {cnt[3], cnt[1], cnt[0]};
   logic [7:0] rdata_o;
   logic fast_on, ext_on, sys_clk;
   logic [1:0] act;
   int n_fail = 0;
   int checks = 0;
   row_s rows [12];
   row_s e;
   always #2.5 mclk_i = ~mclk_i;
   always @(posedge mclk_i) #1 cnt = cnt + 4'h1;
   clk_switch u_dut (.mclk_i(mclk_i), .rst_i(rst_i), .wr_i(wr_i),
      .addr_i(addr_i), .wdata_i(wdata_i), .unlock_i(unlock_i),
      .rdata_o(rdata_o), .fast_osc_ready_i(rdy[2]),
      .slow_osc_ready_i(rdy[1]), .ext_clock_ready_i(rdy[0]),
      .self_program_enable_i(prog), .osc_i(osc), .fast_osc_on_o(fast_on),
      .ext_clock_pin_on_o(ext_on), .active_src_o(act), .sys_clk_o(sys_clk));
   task automatic final_report;
      $display("checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : final_report
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : cmp
   // called just after an edge; the strobe stays up exactly one edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic u);
      addr_i = a;
      wdata_i = d;
      unlock_i = u;
      wr_i = 1'b1;
      @(posedge mclk_i) #1 wr_i = 1'b0;
      unlock_i = 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] m,
      input logic [7:0] exp);
      addr_i = a;
      @(posedge mclk_i) #1 cmp(rdata_o & m, exp);
   endtask : rd
   task automatic idle(input int n);
      repeat (n) @(posedge mclk_i);
      #1;
   endtask : idle
   initial
   begin
      #100000 n_fail++;
      final_report();
   end
   initial
   begin
      // fields: write, addr, data, ready fast/slow/ext, active, switch, enable
      rows = '{'{1, 8'h96, 8'h04, 3'h6, 2'h2, 8'h34, 8'h20},
         '{1, 8'h97, 8'h00, 3'h6, 2'h2, 8'h14, 8'h00},
         '{1, 8'h96, 8'h00, 3'h6, 2'h2, 8'h10, 8'h01},
         '{1, 8'h97, 8'h20, 3'h2, 2'h2, 8'h10, 8'h21},
         '{0, 8'h00, 8'h00, 3'h6, 2'h0, 8'h30, 8'h20},
         '{1, 8'h97, 8'h00, 3'h6, 2'h0, 8'h30, 8'h20},
         '{1, 8'h97, 8'he0, 3'h6, 2'h0, 8'h30, 8'he0},
         '{1, 8'h96, 8'h02, 3'h6, 2'h0, 8'h32, 8'he1},
         '{0, 8'h00, 8'h00, 3'h7, 2'h1, 8'h3a, 8'he0},
         '{1, 8'h97, 8'ha0, 3'h7, 2'h1, 8'h3a, 8'he0},
         '{1, 8'h96, 8'h06, 3'h7, 2'h1, 8'h3e, 8'he1},
         '{1, 8'h96, 8'h02, 3'h7, 2'h1, 8'h3a, 8'he0}};
      repeat (6) @(posedge mclk_i);
      #1 rst_i = 1'b0;
      idle(4);
      cmp({6'h0, act}, {6'h0, src_fast});
      cmp({7'h0, fast_on}, 8'h01);
      @(negedge mclk_i) cmp({7'h0, sys_clk}, {7'h0, osc[0]});
      @(posedge mclk_i) #1;
      rd(switch_addr, 8'hff, switch_reset);
      rd(enable_addr, 8'hff, enable_reset);
      $display("reset test done");
      for (int i = 0; i < 12; i++)
      begin
         e = rows[i];
         rdy = e.r;
         if (e.w)
            wr(e.a, e.d, 1'b1);
         idle(12);
         cmp({6'h0, act}, {6'h0, e.act});
         rd(switch_addr, 8'hff, e.sw);
         rd(enable_addr, 8'he1, e.en);
         cmp({7'h0, fast_on}, {7'h0, e.en[5]});
         cmp({7'h0, ext_on}, {7'h0, &e.en[7:6]});
         $display("row %0d done", i);
      end
      // unprotected write must leave the running source alone
      wr(switch_addr, 8'h04, 1'b0);
      idle(12);
      cmp({6'h0, act}, {6'h0, src_ext});
      @(negedge mclk_i) cmp({7'h0, sys_clk}, {7'h0, osc[1]});
      @(posedge mclk_i) #1;
      rd(switch_addr, 8'hff, 8'h3a);
      $display("unlock test done");
      wr(enable_addr, 8'hc0, 1'b1);
      idle(4);
      rd(enable_addr, 8'he1, 8'hc0);
      prog = 1'b1;
      idle(4);
      cmp({7'h0, fast_on}, 8'h01);
      rd(enable_addr, 8'he1, 8'he0);
      rd(switch_addr, 8'hff, 8'h3a);
      prog = 1'b0;
      idle(4);
      cmp({7'h0, fast_on}, 8'h00);
      rd(enable_addr, 8'he1, 8'hc0);
      $display("self program test done");
      final_report();
   end
endmodule : tb
`default_nettype wire
